// ### design/sdsw_top.sv
// Function
// RL1: host mailbox 0 flag reads 1 while pending, 0 otherwise, 0 at reset.
// RL2: flag clears itself after the host reads it.
// RL3: bit 7 shows up channel 1 busy, 0 at reset.
// RL4: bit 6 shows up channel 0 busy, 0 at reset.
// RL5: bit 5 shows down channel 1 busy, read-only on both sides.
// RL6: bit 4 shows down channel 0 busy, read-only on both sides.
// RL7: bit 3 up channel 1 data waiting, local read/write, host read.
// RL8: bit 2 up channel 0 data waiting, local read/write, host read.
// RL9: bit 1 selects up channel for next transfer, local write.
// RL10: bit 0 selects down channel for next transfer, local write.
// RL11: data window host write-only, no local access, resets to zero.
// RL12: each host window write goes to selected down channel in order; writes made while the queue is full are dropped.
`timescale 1ns/100ps
`default_nettype none
module sdsw_top (
    input wire logic i_clk, // 100 MHz clock
    input wire logic i_arst_n, // async reset, low
    input wire sdsw_pkg::sdsw_req_t i_host, // host register access
    output logic [7:0] o_host_rdata, // host read data
    output logic o_host_rvalid, // host read data valid
    output logic o_host_wready, // window can take a byte
    input wire sdsw_pkg::sdsw_req_t i_loc, // local cpu access
    output logic [7:0] o_loc_rdata, // local read data
    output logic o_loc_rvalid, // local read data valid
    input wire logic i_host_box0_set, // local raises host mailbox 0
    input wire logic [1:0] i_up_busy, // up channels transferring
    input wire logic i_down_sink_ready, // down channel accepts
    output logic [1:0] o_down_valid, // per-channel byte strobe
    output logic [7:0] o_down_data, // byte to down channel
    output logic o_host_box0_irq_flag, // mailbox 0 pending
    output logic o_up_next_channel_sel, // next up channel
    output logic o_down_next_channel_sel // next down channel
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [16:0] a, input logic [16:0] r);
        hit = (a == r);
    endfunction

    logic host_rd_ctl;
    logic host_rd_box;
    logic host_wr_win;
    logic loc_wr_ctl;
    logic [7:0] ctl;
    logic [1:0] down_busy;
    logic [1:0] down_valid;
    logic [7:0] down_data;
    logic fifo_ready;
    logic q_valid;
    logic q_ready;
    logic sink_take;
    sdsw_pkg::sdsw_beat_t q_beat;
    sdsw_pkg::sdsw_beat_t in_beat;

    logic host_box0_irq_flag_q;
    logic [1:0] up_wait_q;
    logic up_next_channel_sel_q;
    logic down_next_channel_sel_q;
    logic [1:0] up_busy_q;
    logic [7:0] transfer_window_byte_q;

    assign host_rd_ctl = i_host.rd &&
        hit(i_host.addr, sdsw_pkg::DMA_STATUS_CONTROL_ADDR);
    assign host_rd_box = i_host.rd &&
        hit(i_host.addr, sdsw_pkg::HOST_BOX_STATUS_ADDR);
    // host writes to the control byte are ignored
    assign host_wr_win = i_host.wr && fifo_ready &&
        hit(i_host.addr, sdsw_pkg::HOST_TO_FUNCTION_DATA_WINDOW_ADDR); // RL11
    assign loc_wr_ctl = i_loc.wr &&
        hit(i_loc.addr, sdsw_pkg::DMA_STATUS_CONTROL_ADDR);

    // byte pins are registered: an accept only counts once the sink
    // can actually see the strobe, else a byte could slip past unseen
    assign sink_take = i_down_sink_ready && (|o_down_valid); // RL12

    // ----------------------------------------------------------------
    // status/control byte
    // ----------------------------------------------------------------
    always_comb
    begin
        ctl = sdsw_pkg::BYTE_RESET;
        ctl[sdsw_pkg::UP_CH1_BUSY_BIT] = up_busy_q[1]; // RL3
        ctl[sdsw_pkg::UP_CH0_BUSY_BIT] = up_busy_q[0]; // RL4
        ctl[sdsw_pkg::DOWN_CH1_BUSY_BIT] = down_busy[1]; // RL5
        ctl[sdsw_pkg::DOWN_CH0_BUSY_BIT] = down_busy[0]; // RL6
        ctl[sdsw_pkg::UP_CH1_WAIT_BIT] = up_wait_q[1]; // RL7
        ctl[sdsw_pkg::UP_CH0_WAIT_BIT] = up_wait_q[0]; // RL8
        ctl[sdsw_pkg::UP_NEXT_SEL_BIT] = up_next_channel_sel_q; // RL9
        ctl[sdsw_pkg::DOWN_NEXT_SEL_BIT] = down_next_channel_sel_q; // RL10
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            up_busy_q <= 2'h0;
        end
        else
        begin
            up_busy_q <= i_up_busy; // RL3 RL4
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            up_wait_q <= 2'h0;
        end
        else if (loc_wr_ctl)
        begin
            // busy bits are not writable from either side
            up_wait_q[1] <= i_loc.wdata[sdsw_pkg::UP_CH1_WAIT_BIT]; // RL7
            up_wait_q[0] <= i_loc.wdata[sdsw_pkg::UP_CH0_WAIT_BIT]; // RL8
        end
    end

    // ----------------------------------------------------------------
    // next-channel selects, local write only
    // ----------------------------------------------------------------
    // a new down select only steers bytes written after it
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            up_next_channel_sel_q <= 1'b0;
            down_next_channel_sel_q <= 1'b0;
        end
        else if (loc_wr_ctl)
        begin
            up_next_channel_sel_q <=
                i_loc.wdata[sdsw_pkg::UP_NEXT_SEL_BIT]; // RL9
            down_next_channel_sel_q <=
                i_loc.wdata[sdsw_pkg::DOWN_NEXT_SEL_BIT]; // RL10
        end
    end

    // ----------------------------------------------------------------
    // host mailbox 0 flag
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            host_box0_irq_flag_q <= 1'b0; // RL1
        end
        else if (i_host_box0_set)
        begin
            // a new event beats the clear from a same-cycle read
            host_box0_irq_flag_q <= 1'b1; // RL1
        end
        else if (host_rd_box)
        begin
            host_box0_irq_flag_q <= 1'b0; // RL2
        end
    end

    // ----------------------------------------------------------------
    // data window and queue
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            transfer_window_byte_q <= sdsw_pkg::BYTE_RESET; // RL11
        end
        else if (host_wr_win)
        begin
            transfer_window_byte_q <= i_host.wdata;
        end
    end

    // channel tagged at write time so later select changes do not reroute
    assign in_beat.chan = down_next_channel_sel_q; // RL12
    assign in_beat.data = i_host.wdata;

    sdsw_fifo #(
        .WIDTH(sdsw_pkg::FIFO_WIDTH + 1),
        .DEPTH(sdsw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(host_wr_win), // RL12
        .o_ready(fifo_ready),
        .i_data(in_beat),
        .o_valid(q_valid),
        .i_ready(q_ready),
        .o_data(q_beat)
    );

    sdsw_down_engine u_eng (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(q_valid),
        .o_ready(q_ready),
        .i_beat(q_beat),
        .i_sink_ready(sink_take),
        .o_busy(down_busy),
        .o_valid(down_valid),
        .o_data(down_data)
    );

    // ----------------------------------------------------------------
    // read ports and registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_rdata <= sdsw_pkg::BYTE_RESET;
        end
        else
        begin
            if (host_rd_ctl)
            begin
                o_host_rdata <= ctl;
            end
            else if (host_rd_box)
            begin
                o_host_rdata <= {7'h00, host_box0_irq_flag_q}; // RL1
            end
            else
            begin
                // window reads back zero: it is write-only
                o_host_rdata <= sdsw_pkg::BYTE_RESET; // RL11
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_loc_rdata <= sdsw_pkg::BYTE_RESET;
        end
        else
        begin
            if (i_loc.rd && hit(i_loc.addr, sdsw_pkg::DMA_STATUS_CONTROL_ADDR))
            begin
                o_loc_rdata <= ctl;
            end
            else if (i_loc.rd &&
                hit(i_loc.addr, sdsw_pkg::HOST_BOX_STATUS_ADDR))
            begin
                o_loc_rdata <= {7'h00, host_box0_irq_flag_q};
            end
            else
            begin
                o_loc_rdata <= sdsw_pkg::BYTE_RESET; // RL11
            end
        end
    end

    // lags the queue by a cycle: a write just after the one that
    // filled the queue is still dropped, so writers leave a gap
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_wready <= 1'b0;
        end
        else
        begin
            o_host_wready <= fifo_ready;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_rvalid <= 1'b0;
        end
        else
        begin
            o_host_rvalid <= i_host.rd;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_loc_rvalid <= 1'b0;
        end
        else
        begin
            o_loc_rvalid <= i_loc.rd;
        end
    end

    // strobe stands one cycle past the accept; sinks take one per rise
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_down_valid <= 2'h0;
            o_down_data <= sdsw_pkg::BYTE_RESET;
        end
        else
        begin
            o_down_valid <= down_valid; // RL12
            o_down_data <= down_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_host_box0_irq_flag <= 1'b0;
        end
        else
        begin
            o_host_box0_irq_flag <= host_box0_irq_flag_q; // RL1
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_up_next_channel_sel <= 1'b0;
            o_down_next_channel_sel <= 1'b0;
        end
        else
        begin
            o_up_next_channel_sel <= up_next_channel_sel_q; // RL9
            o_down_next_channel_sel <= down_next_channel_sel_q; // RL10
        end
    end
endmodule
`default_nettype wire

// ### design/sdsw_pkg.sv
`default_nettype none
package sdsw_pkg;

    // ----------------------------------------------------------------
    // register map (function 1 byte addresses)
    // ----------------------------------------------------------------
    localparam logic [16:0] DMA_STATUS_CONTROL_ADDR = 17'h00108;
    localparam logic [16:0] HOST_TO_FUNCTION_DATA_WINDOW_ADDR = 17'h0010C;
    localparam logic [16:0] HOST_BOX_STATUS_ADDR = 17'h00104;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int UP_CH1_BUSY_BIT = 7;
    localparam int UP_CH0_BUSY_BIT = 6;
    localparam int DOWN_CH1_BUSY_BIT = 5;
    localparam int DOWN_CH0_BUSY_BIT = 4;
    localparam int UP_CH1_WAIT_BIT = 3;
    localparam int UP_CH0_WAIT_BIT = 2;
    localparam int UP_NEXT_SEL_BIT = 1;
    localparam int DOWN_NEXT_SEL_BIT = 0;
    localparam int HOST_BOX0_FLAG_BIT = 0;

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] LOCAL_WRITE_MASK = 8'h0F;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [16:0] addr;
        logic [7:0]  wdata;
    } sdsw_req_t;

    typedef struct packed {
        logic       chan;
        logic [7:0] data;
    } sdsw_beat_t;

    typedef enum logic [1:0] {
        SDSW_IDLE = 2'b00,
        SDSW_MOVE = 2'b01,
        SDSW_DONE = 2'b10
    } sdsw_down_state_t;

endpackage
`default_nettype wire

// ### design/sdsw_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sdsw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic i_clk, // clock
    input wire logic i_arst_n, // async reset, low
    input wire logic i_valid, // write strobe
    output logic o_ready, // room available
    input wire logic [WIDTH-1:0] i_data, // write data
    output logic o_valid, // data available
    input wire logic i_ready, // read accept
    output logic [WIDTH-1:0] o_data // head of queue
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // count is one bit wider than the pointers so full and empty differ
    assign o_ready = cnt_q < (AW+1)'(DEPTH);
    assign o_valid = cnt_q != '0;
    assign o_data = mem[rp_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wp_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### design/sdsw_down_engine.sv
`timescale 1ns/100ps
`default_nettype none
module sdsw_down_engine (
    input wire logic i_clk, // clock
    input wire logic i_arst_n, // async reset, low
    input wire logic i_valid, // beat from queue
    output logic o_ready, // beat taken
    input wire sdsw_pkg::sdsw_beat_t i_beat, // channel and byte
    input wire logic i_sink_ready, // channel sink accepts
    output logic [1:0] o_busy, // per-channel transfer ongoing
    output logic [1:0] o_valid, // per-channel strobe
    output logic [7:0] o_data // byte to channel
);
    sdsw_pkg::sdsw_down_state_t st_q;
    sdsw_pkg::sdsw_beat_t cur_q;

    // one beat in flight; the sink can stall and the queue then fills
    assign o_ready = (st_q == sdsw_pkg::SDSW_IDLE);
    assign o_data = cur_q.data;
    assign o_valid[0] = (st_q == sdsw_pkg::SDSW_MOVE) && !cur_q.chan;
    assign o_valid[1] = (st_q == sdsw_pkg::SDSW_MOVE) && cur_q.chan;
    assign o_busy = o_valid;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q <= sdsw_pkg::SDSW_IDLE;
            cur_q <= '0;
        end
        else
        begin
            case (st_q)
                sdsw_pkg::SDSW_IDLE:
                begin
                    if (i_valid)
                    begin
                        cur_q <= i_beat;
                        st_q <= sdsw_pkg::SDSW_MOVE;
                    end
                end
                sdsw_pkg::SDSW_MOVE:
                begin
                    if (i_sink_ready)
                    begin
                        st_q <= sdsw_pkg::SDSW_DONE;
                    end
                end
                default:
                begin
                    st_q <= sdsw_pkg::SDSW_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/sdsw_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sdsw_top_checker (
    input wire logic i_clk, // clock
    input wire logic i_arst_n, // reset
    input wire sdsw_pkg::sdsw_req_t i_host, // host req
    input wire logic [7:0] o_host_rdata, // host data
    input wire sdsw_pkg::sdsw_req_t i_loc, // local req
    input wire logic [7:0] o_loc_rdata, // local data
    input wire logic i_host_box0_set, // flag set
    input wire logic [1:0] i_up_busy, // up busy
    input wire logic i_down_sink_ready, // sink ready
    input wire logic [1:0] o_down_valid, // strobes
    input wire logic [7:0] o_down_data, // byte
    input wire logic o_host_box0_irq_flag, // flag
    input wire logic o_up_next_channel_sel, // up sel
    input wire logic o_down_next_channel_sel // down sel
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    logic st_rd;
    logic box_rd;
    logic st_lw;
    logic win_lr;
    logic [1:0] sel;
    assign st_rd = i_host.rd
        && i_host.addr == sdsw_pkg::DMA_STATUS_CONTROL_ADDR;
    assign box_rd = i_host.rd && i_host.addr == sdsw_pkg::HOST_BOX_STATUS_ADDR;
    assign st_lw = i_loc.wr && i_loc.addr == sdsw_pkg::DMA_STATUS_CONTROL_ADDR;
    assign win_lr = i_loc.rd
        && i_loc.addr == sdsw_pkg::HOST_TO_FUNCTION_DATA_WINDOW_ADDR;
    assign sel = {o_up_next_channel_sel, o_down_next_channel_sel};

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // flag and select pins sit two registers behind the request
    property p_flag_set;
        i_host_box0_set |-> ##2 o_host_box0_irq_flag;
    endproperty
    property p_flag_clr;
        box_rd && !i_host_box0_set ##1 !i_host_box0_set
        |=> !o_host_box0_irq_flag;
    endproperty
    property p_sel;
        st_lw |-> ##2 sel == $past(i_loc.wdata[1:0], 2);
    endproperty
    property p_host_ro;
        i_host.wr && !i_loc.wr |-> ##2 $stable(sel);
    endproperty
    property p_up_busy;
        st_rd |=> o_host_rdata[7:6] == $past(i_up_busy, 2);
    endproperty
    property p_stat_sel;
        st_rd |=> o_host_rdata[1:0] == sel;
    endproperty
    property p_loc_win;
        win_lr |=> o_loc_rdata == 8'h00;
    endproperty
    // strobe holds while the sink has not yet been seen ready
    property p_hold;
        (|o_down_valid) && !i_down_sink_ready && !$past(i_down_sink_ready)
        |=> o_down_valid == $past(o_down_valid) && $stable(o_down_data);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("mailbox flag not set");
    a_flag_clr: assert property (p_flag_clr)
        else $error("mailbox flag not cleared by host read");
    a_sel: assert property (p_sel)
        else $error("channel select not written locally");
    a_host_ro: assert property (p_host_ro)
        else $error("host write changed channel select");
    a_up_busy: assert property (p_up_busy)
        else $error("up busy bits wrong in status read");
    a_stat_sel: assert property (p_stat_sel)
        else $error("select bits wrong in status read");
    a_loc_win: assert property (p_loc_win)
        else $error("local window read not zero");
    a_hold: assert property (p_hold)
        else $error("down strobe dropped before accept");
    c_flag: cover property (box_rd && o_host_box0_irq_flag);
    c_stat: cover property (st_rd && (|i_up_busy));
    c_beat: cover property ((|o_down_valid) && i_down_sink_ready);
endmodule
bind sdsw_top sdsw_top_checker chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_host(i_host), .o_host_rdata(o_host_rdata), .i_loc(i_loc),
    .o_loc_rdata(o_loc_rdata), .i_host_box0_set(i_host_box0_set),
    .i_up_busy(i_up_busy), .i_down_sink_ready(i_down_sink_ready),
    .o_down_valid(o_down_valid), .o_down_data(o_down_data),
    .o_host_box0_irq_flag(o_host_box0_irq_flag),
    .o_up_next_channel_sel(o_up_next_channel_sel),
    .o_down_next_channel_sel(o_down_next_channel_sel));
`default_nettype wire

// ### verification/sdsw_sink_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdsw_sink_model (
    input wire logic i_clk, // clock
    input wire logic i_arst_n, // reset
    input wire logic i_stall, // hold off
    input wire logic [1:0] i_valid, // strobes
    input wire logic [7:0] i_data, // byte
    output logic o_ready // accept
);
    logic armed;
    logic [8:0] got[$];
    // one byte per strobe: re-arm only once the strobe has dropped
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ready <= 1'b0;
            armed <= 1'b1;
        end
        else
        begin
            o_ready <= !i_stall && ($urandom_range(0, 2) != 0);
            if (i_valid == 2'h0)
                armed <= 1'b1;
            else if (o_ready && armed)
            begin
                got.push_back({i_valid[1], i_data});
                armed <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_sdsw_dma_status_window.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sdsw_dma_status_window;
    localparam logic [16:0] ST = sdsw_pkg::DMA_STATUS_CONTROL_ADDR;
    localparam logic [16:0] WN = sdsw_pkg::HOST_TO_FUNCTION_DATA_WINDOW_ADDR;
    localparam logic [16:0] BX = sdsw_pkg::HOST_BOX_STATUS_ADDR;
    logic i_clk, i_arst_n, set, rdy, stall, hrv, lrv, wrdy, flag, us, ds;
    logic [1:0] ub, dv;
    logic [7:0] hrd, lrd, dd, q, d;
    logic [3:0] lo;
    logic [8:0] exp_q[$];
    sdsw_pkg::sdsw_req_t hreq, lreq;
    int errors, checks_done;
    bit refused;

    sdsw_top dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_host(hreq),
        .o_host_rdata(hrd), .o_host_rvalid(hrv), .o_host_wready(wrdy),
        .i_loc(lreq), .o_loc_rdata(lrd), .o_loc_rvalid(lrv),
        .i_host_box0_set(set), .i_up_busy(ub), .i_down_sink_ready(rdy),
        .o_down_valid(dv), .o_down_data(dd), .o_host_box0_irq_flag(flag),
        .o_up_next_channel_sel(us), .o_down_next_channel_sel(ds));
    sdsw_sink_model sink_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_stall(stall), .i_valid(dv), .i_data(dd), .o_ready(rdy));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function logic [7:0] stat(input logic [1:0] u, input logic [1:0] w,
        input logic [3:0] l);
        return {u, w, l};
    endfunction

    task conclude;
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input logic [8:0] s, input logic [8:0] e, input string n);
        checks_done++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task acc(input bit l, input bit r, input logic [16:0] a,
        input logic [7:0] w);
        @(posedge i_clk);
        if (l)
            lreq <= '{r, !r, a, w};
        else
            hreq <= '{r, !r, a, w};
        @(posedge i_clk);
        lreq <= '0;
        hreq <= '0;
        #1;
        q = l ? lrd : hrd;
        if (r)
            chk(9'(l ? lrv : hrv), 9'h001, "rvalid");
    endtask

    task rd_chk(input bit l, input logic [16:0] a, input logic [7:0] e,
        input string n);
        acc(l, 1'b1, a, 8'h00);
        chk(9'(q), 9'(e), n);
    endtask

    // gap keeps the lagging ready flag exact at the write
    task win(input logic [7:0] b);
        repeat (2) @(posedge i_clk);
        #1;
        if (wrdy === 1'b1)
            exp_q.push_back({lo[0], b});
        else
            refused = 1'b1;
        acc(1'b0, 1'b0, WN, b);
    endtask

    task drain;
        int i;
        for (i = 0; i < 3000 && sink_u.got.size() < exp_q.size(); i++)
            @(posedge i_clk);
        repeat (20) @(posedge i_clk);
        if (i == 3000)
        begin
            errors++;
            conclude;
        end
        else
        begin
            chk(9'(sink_u.got.size()), 9'(exp_q.size()), "count");
            foreach (exp_q[k])
                chk(sink_u.got[k], exp_q[k], "beat");
            exp_q.delete();
            sink_u.got.delete();
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        i_arst_n = 1'b0;
        hreq = '0;
        lreq = '0;
        set = 1'b0;
        ub = 2'h0;
        stall = 1'b0;
        lo = 4'h0;
        errors = 0;
        checks_done = 0;
        refused = 1'b0;
        void'($urandom(64446));
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd_chk(0, ST, 8'h00, "stat_rst");
        rd_chk(0, BX, 8'h00, "box_rst");
        rd_chk(1, WN, 8'h00, "loc_win");
        rd_chk(0, WN, 8'h00, "host_win");
        rd_chk(0, 17'h00100, 8'h00, "unmapped");
        repeat (8)
        begin
            @(posedge i_clk);
            ub <= 2'($urandom);
            d = 8'($urandom);
            lo = d[3:0];
            acc(1'b1, 1'b0, ST, d);
            acc(1'b0, 1'b0, ST, ~d);
            rd_chk(0, ST, stat(ub, 2'h0, lo), "stat");
            rd_chk(1, ST, stat(ub, 2'h0, lo), "loc_stat");
        end
        @(posedge i_clk);
        set <= 1'b1;
        @(posedge i_clk);
        set <= 1'b0;
        rd_chk(0, BX, 8'h01, "box_set");
        rd_chk(0, BX, 8'h00, "box_clr");
        repeat (16)
        begin
            if ($urandom_range(0, 1) == 1)
            begin
                lo[0] = ~lo[0];
                acc(1'b1, 1'b0, ST, {4'h0, lo});
            end
            win(8'($urandom));
        end
        drain;
        @(posedge i_clk);
        stall <= 1'b1;
        win(8'hA5);
        repeat (8) @(posedge i_clk);
        rd_chk(0, ST, stat(ub, lo[0] ? 2'h2 : 2'h1, lo), "busy");
        repeat (40) win(8'($urandom));
        chk(9'(refused), 9'h001, "full");
        @(posedge i_clk);
        stall <= 1'b0;
        drain;
        conclude;
    end
endmodule
`default_nettype wire
